//--- hdl/aldzr_defines.svh
// Offsets, field positions, reset values and timing counts of the dark-zone readout.
`ifndef ALDZR_DEFINES_SVH
`define ALDZR_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ALDZR_OFS_DARK_THR  8'h38
`define ALDZR_OFS_DARK_HYS  8'h39
`define ALDZR_OFS_S1_LOW    8'h40
`define ALDZR_OFS_S1_HIGH   8'h41
`define ALDZR_OFS_S2_LOW    8'h42
`define ALDZR_OFS_S2_HIGH   8'h43
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define ALDZR_RST_DARK_THR  8'h00
`define ALDZR_RST_DARK_HYS  8'h00
`define ALDZR_RST_COUNT     13'h0000
`define ALDZR_RST_HIGH      5'h00
`define ALDZR_RESV_HIGH     3'h0
`define ALDZR_HIGH_MSB      12
`define ALDZR_HIGH_LSB      8
`define ALDZR_LOW_MSB       7
`define ALDZR_COUNT_MAX     13'h1f40
`define ALDZR_COUNT_SCALE   48'h000000001f40
`define ALDZR_STEP_NA       48'h00000000021c
`define ALDZR_LEVEL_INDOOR  3'h4
`define ALDZR_LEVEL_DARK    3'h5
// ----------------------------------------
// Timing
// ----------------------------------------
`define ALDZR_REFRESH_MS    80
`define ALDZR_CLK_KHZ       40000
`define ALDZR_REFRESH_CYCLES (`ALDZR_REFRESH_MS * `ALDZR_CLK_KHZ)
`define ALDZR_FULL_SCALE_NA 137700
`endif

//--- hdl/aldzr_pkg.sv
// Types shared by the dark-zone readout.
package aldzr_pkg;
  // Zone held by the darkest-zone comparator.
  typedef enum logic [0:0] {
    ALDZR_ZONE_INDOOR = 1'b0,
    ALDZR_ZONE_DARK   = 1'b1
  } aldzr_zone_t;
endpackage

//--- hdl/aldzr_top.sv
// Dark-zone comparator and two read-only light sensor results.
`timescale 1ns/1ps
`include "aldzr_defines.svh"
// ----------------------------------------
// ----------------------------------------
module aldzr_top
  import aldzr_pkg::*;
#(
  parameter int REFRESH_CYCLES = `ALDZR_REFRESH_CYCLES,
  parameter int FULL_SCALE_NA  = `ALDZR_FULL_SCALE_NA
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Register port from the serial interface.
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Analog front end, asynchronous to mclk.
  input  wire logic        ambient_light_sensing,
  input  wire logic [12:0] sensor_one_count_in,
  input  wire logic [12:0] sensor_two_count_in,
  // Backlight level request.
  output logic      [2:0]  backlight_level,
  output logic             dark_zone_active,
  output logic             result_update
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Caps a raw count at the documented maximum.
  function automatic logic [12:0] clamp_count(input logic [12:0] c);
    clamp_count = (c > `ALDZR_COUNT_MAX) ? `ALDZR_COUNT_MAX : c;
  endfunction

  // Current of a count in nA, times 8000, so no division is needed.
  function automatic logic [47:0] count_scaled(input logic [12:0] c);
    count_scaled = {35'h0, c} * 48'(FULL_SCALE_NA);
  endfunction

  // Current of a threshold code in nA, times 8000.
  function automatic logic [47:0] code_scaled(input logic [8:0] code);
    code_scaled = {39'h0, code} * `ALDZR_STEP_NA * `ALDZR_COUNT_SCALE;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------

  logic        en_m_q;  // First stage of the enable.
  logic        en_q;    // Synchronised enable.
  logic [12:0] s1_m_q;  // First stage, sensor one.
  logic [12:0] s1_q;    // Synchronised sensor one.
  logic [12:0] s2_m_q;  // First stage, sensor two.
  logic [12:0] s2_q;    // Synchronised sensor two.
  logic [12:0] s1_p_q;  // Previous synchronised sample, sensor one.
  logic [12:0] s2_p_q;  // Previous synchronised sample, sensor two.

  // Each bit is synchronised on its own, so a count caught while it changes
  // can be far off for a cycle; later logic only uses a sample that repeats.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_m_q <= 1'b0;
      en_q   <= 1'b0;
      s1_m_q <= `ALDZR_RST_COUNT;
      s1_q   <= `ALDZR_RST_COUNT;
      s2_m_q <= `ALDZR_RST_COUNT;
      s2_q   <= `ALDZR_RST_COUNT;
      s1_p_q <= `ALDZR_RST_COUNT;
      s2_p_q <= `ALDZR_RST_COUNT;
    end else begin
      en_m_q <= ambient_light_sensing;
      en_q   <= en_m_q;
      s1_m_q <= sensor_one_count_in;
      s1_q   <= s1_m_q;
      s2_m_q <= sensor_two_count_in;
      s2_q   <= s2_m_q;
      s1_p_q <= s1_q;
      s2_p_q <= s2_q;
    end
  end

  // ----------------------------------------
  // Refresh timer
  // ----------------------------------------

  localparam logic [31:0] REFRESH_LAST = 32'(REFRESH_CYCLES - 1);

  logic [31:0] cnt_q;  // Cycles into the current period.
  logic [31:0] cnt_d;  // Next period count.
  logic        tick;   // One-cycle refresh enable.

  // The timer restarts whenever sensing is switched off.
  always_comb begin
    tick  = en_q && (cnt_q == REFRESH_LAST);
    cnt_d = cnt_q + 32'h1;
    if (!en_q || tick) begin
      cnt_d = 32'h0;
    end
  end

  // Registers the timer.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Conversion results
  // ----------------------------------------

  logic [12:0] new1;    // Capped sample, sensor one.
  logic [12:0] new2;    // Capped sample, sensor two.
  logic [12:0] res1_q;  // Stored count, sensor one.
  logic [12:0] res1_d;
  logic [12:0] res2_q;  // Stored count, sensor two.
  logic [12:0] res2_d;
  logic [4:0]  hi1_q;   // High part frozen at the low read.
  logic [4:0]  hi1_d;
  logic [4:0]  hi2_q;
  logic [4:0]  hi2_d;
  logic        rd_s1_low;
  logic        rd_s2_low;

  // Results change only on the refresh tick; writes never reach them.
  always_comb begin
    // A sample that differs from the one before may be torn, so the old result is kept then.
    new1      = (s1_q == s1_p_q) ? clamp_count(s1_q) : res1_q;
    new2      = (s2_q == s2_p_q) ? clamp_count(s2_q) : res2_q;
    rd_s1_low = reg_rd && (reg_addr == `ALDZR_OFS_S1_LOW);
    rd_s2_low = reg_rd && (reg_addr == `ALDZR_OFS_S2_LOW);
    res1_d    = tick ? new1 : res1_q;
    res2_d    = tick ? new2 : res2_q;
    hi1_d     = hi1_q;
    hi2_d     = hi2_q;
    // Reading the low byte freezes the high part, so the pair matches.
    if (rd_s1_low) begin
      hi1_d = res1_q[`ALDZR_HIGH_MSB:`ALDZR_HIGH_LSB];
    end
    if (rd_s2_low) begin
      hi2_d = res2_q[`ALDZR_HIGH_MSB:`ALDZR_HIGH_LSB];
    end
  end

  // Registers the results and shadows.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      res1_q <= `ALDZR_RST_COUNT;
      res2_q <= `ALDZR_RST_COUNT;
      hi1_q  <= `ALDZR_RST_HIGH;
      hi2_q  <= `ALDZR_RST_HIGH;
    end else begin
      res1_q <= res1_d;
      res2_q <= res2_d;
      hi1_q  <= hi1_d;
      hi2_q  <= hi2_d;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------

  logic [7:0] thr_q;  // Dark entry threshold code.
  logic [7:0] thr_d;
  logic [7:0] hys_q;  // Dark exit hysteresis code.
  logic [7:0] hys_d;

  // Only the two control offsets take writes.
  always_comb begin
    thr_d = thr_q;
    hys_d = hys_q;
    if (reg_wr && (reg_addr == `ALDZR_OFS_DARK_THR)) begin
      thr_d = reg_wdata;
    end
    if (reg_wr && (reg_addr == `ALDZR_OFS_DARK_HYS)) begin
      hys_d = reg_wdata;
    end
  end

  // Registers the control codes.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      thr_q <= `ALDZR_RST_DARK_THR;
      hys_q <= `ALDZR_RST_DARK_HYS;
    end else begin
      thr_q <= thr_d;
      hys_q <= hys_d;
    end
  end

  // ----------------------------------------
  // Darkest-zone comparator
  // ----------------------------------------

  aldzr_zone_t zone_q;  // Current zone.
  aldzr_zone_t zone_d;
  logic        below;   // Fresh sample under the threshold.
  logic        above;   // Fresh sample over threshold plus hysteresis.
  logic [8:0]  exit_code;

  // Sensor one drives the comparator; it is judged once per refresh.
  always_comb begin
    exit_code = {1'b0, thr_q} + {1'b0, hys_q};
    below     = count_scaled(new1) < code_scaled({1'b0, thr_q});
    above     = count_scaled(new1) > code_scaled(exit_code);
    zone_d    = zone_q;
    if (tick) begin
      case (zone_q)
        ALDZR_ZONE_INDOOR: begin
          if (below) begin
            zone_d = ALDZR_ZONE_DARK;
          end
        end
        ALDZR_ZONE_DARK: begin
          if (above) begin
            zone_d = ALDZR_ZONE_INDOOR;
          end
        end
        default: begin
          zone_d = ALDZR_ZONE_INDOOR;
        end
      endcase
    end
  end

  // Registers the zone and its level outputs.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zone_q          <= ALDZR_ZONE_INDOOR;
      dark_zone_active <= 1'b0;
      backlight_level <= `ALDZR_LEVEL_INDOOR;
      result_update   <= 1'b0;
    end else begin
      zone_q           <= zone_d;
      dark_zone_active <= (zone_d == ALDZR_ZONE_DARK);
      backlight_level  <= (zone_d == ALDZR_ZONE_DARK) ? `ALDZR_LEVEL_DARK : `ALDZR_LEVEL_INDOOR;
      result_update    <= tick;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------

  logic [7:0] rdata_d;

  // Unmapped offsets read as zero; reserved high bits read as zero.
  always_comb begin
    case (reg_addr)
      `ALDZR_OFS_DARK_THR: rdata_d = thr_q;
      `ALDZR_OFS_DARK_HYS: rdata_d = hys_q;
      `ALDZR_OFS_S1_LOW:   rdata_d = res1_q[`ALDZR_LOW_MSB:0];
      `ALDZR_OFS_S1_HIGH:  rdata_d = {`ALDZR_RESV_HIGH, hi1_q};
      `ALDZR_OFS_S2_LOW:   rdata_d = res2_q[`ALDZR_LOW_MSB:0];
      `ALDZR_OFS_S2_HIGH:  rdata_d = {`ALDZR_RESV_HIGH, hi2_q};
      default:             rdata_d = 8'h00;
    endcase
  end

  // Registers read data one cycle after the strobe.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_dark_entry: assert property (tick && zone_q == ALDZR_ZONE_INDOOR && below |=> dark_zone_active && backlight_level == 3'h5)
    else $error("dark entry missed");
  a_dark_exit: assert property (tick && zone_q == ALDZR_ZONE_DARK && above |=> !dark_zone_active && backlight_level == 3'h4)
    else $error("dark exit missed");
  a_zone_hold: assert property (!tick |=> $stable(zone_q))
    else $error("zone moved without refresh");
  a_count_cap: assert property (res1_q <= 13'h1f40 && res2_q <= 13'h1f40)
    else $error("count above cap");
  a_result_load: assert property (tick |=> res1_q == $past(new1) && res2_q == $past(new2))
    else $error("refresh not loaded");
  a_result_hold: assert property (!tick |=> $stable(res1_q) && $stable(res2_q))
    else $error("result changed off tick");
  a_tick_spacing: assert property (tick |=> !tick [*8])
    else $error("refresh too frequent");
  a_high_format: assert property (reg_rd && reg_addr == `ALDZR_OFS_S2_HIGH |=> reg_rvalid && reg_rdata == {3'h0, $past(hi2_q)})
    else $error("high byte format wrong");
  a_pair_match: assert property (rd_s1_low |=> hi1_q == $past(res1_q[12:8]) && reg_rdata == $past(res1_q[7:0]))
    else $error("pair not coherent");
  a_thr_write: assert property (reg_wr && reg_addr == `ALDZR_OFS_DARK_THR |=> thr_q == $past(reg_wdata))
    else $error("threshold write lost");

endmodule

//--- dv/aldzr_front_end_model.sv
// Behavioural model of the phototransistor front end feeding the readout.
`timescale 1ns/1ps
module aldzr_front_end_model (
  // Clock of the bench.
  input  wire logic        mclk,
  // Requested conditions from the bench.
  input  wire logic        cmd_en,
  input  wire logic [12:0] cmd_one,
  input  wire logic [12:0] cmd_two,
  // Outputs towards the readout.
  output logic             ambient_light_sensing,
  output logic      [12:0] sensor_one_count_in,
  output logic      [12:0] sensor_two_count_in
);
  // ----------------------------------------
  // Front end
  // ----------------------------------------
  // Counts only change on a clock edge, so the readout's synchronisers see clean steps.
  // The raw count stays a 13-bit value; values above the cap are allowed on purpose.
  always @(posedge mclk) begin
    ambient_light_sensing <= cmd_en;
    sensor_one_count_in   <= cmd_one;
    sensor_two_count_in   <= cmd_two;
  end
endmodule

//--- dv/aldzr_top_tb_top.sv
// Self-checking testbench of the dark-zone readout.
`timescale 1ns/1ps
`include "aldzr_defines.svh"
module aldzr_top_tb_top;
  import aldzr_pkg::*;
  localparam int REFRESH = 20; // Shortened refresh period keeps the run brief.
  logic        mclk      = 1'b0;
  logic        reset_n   = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        ambient_light_sensing;
  logic [12:0] sensor_one_count_in;
  logic [12:0] sensor_two_count_in;
  logic [2:0]  backlight_level;
  logic        dark_zone_active;
  logic        result_update;
  logic        fe_en     = 1'b0;
  logic [12:0] fe_one    = 13'h0000;
  logic [12:0] fe_two    = 13'h0000;
  int          n_errors  = 0;
  int          n_checks  = 0;
  aldzr_top #(.REFRESH_CYCLES(REFRESH)) i_aldzr_top (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ambient_light_sensing(ambient_light_sensing), .sensor_one_count_in(sensor_one_count_in),
    .sensor_two_count_in(sensor_two_count_in), .backlight_level(backlight_level),
    .dark_zone_active(dark_zone_active), .result_update(result_update));
  aldzr_front_end_model i_aldzr_front_end_model (.mclk(mclk), .cmd_en(fe_en), .cmd_one(fe_one), .cmd_two(fe_two),
    .ambient_light_sensing(ambient_light_sensing), .sensor_one_count_in(sensor_one_count_in),
    .sensor_two_count_in(sensor_two_count_in));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One write strobe of a single cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One read; the answer is taken the cycle after the strobe is seen.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
  endtask
  // Waits for the next result pulse, bounded, and returns the cycles spent.
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (result_update !== 1'b1 && n < 100);
    chk(result_update, 1'b1);
  endtask
  // Zone expected after a refresh, compared in nA scaled by 8000 to avoid rounding.
  function automatic logic exp_dark(logic cur, int cnt, int thr, int hys);
    longint i = longint'(cnt) * `ALDZR_FULL_SCALE_NA;
    if (!cur && i < longint'(thr) * 540 * 8000) return 1'b1;
    if (cur && i > longint'(thr + hys) * 540 * 8000) return 1'b0;
    return cur;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset state of every register and of the level outputs.
  task automatic t_reset();
    #1;
    chk(backlight_level, `ALDZR_LEVEL_INDOOR);
    chk(dark_zone_active, 1'b0);
    for (int a = 8'h38; a <= 8'h43; a++) begin
      rd_chk(a[7:0], 8'h00);
    end
  endtask
  // Writable settings read back; result places and unmapped places ignore writes.
  task automatic t_regs();
    wr(`ALDZR_OFS_DARK_THR, 8'ha5);
    wr(`ALDZR_OFS_DARK_HYS, 8'h5a);
    rd_chk(`ALDZR_OFS_DARK_THR, 8'ha5);
    rd_chk(`ALDZR_OFS_DARK_HYS, 8'h5a);
    for (int a = 8'h40; a <= 8'h43; a++) begin
      wr(a[7:0], 8'hff);
      rd_chk(a[7:0], 8'h00);
    end
    wr(8'h50, 8'h77);
    rd_chk(8'h50, 8'h00);
  endtask
  // Refresh period, byte split, cap and the low-then-high pairing.
  task automatic t_results();
    int n;
    @(posedge mclk);
    fe_en  <= 1'b1;
    fe_one <= 13'h0abc;
    fe_two <= 13'h1fff;
    wait_upd(n);
    wait_upd(n);
    chk(n, REFRESH);
    chk(dark_zone_active, exp_dark(1'b0, 13'h0abc, 8'ha5, 8'h5a));
    rd_chk(`ALDZR_OFS_S1_LOW, 8'hbc);
    rd_chk(`ALDZR_OFS_S2_LOW, 8'h40);
    rd_chk(`ALDZR_OFS_S2_HIGH, 8'h1f);
    rd_chk(`ALDZR_OFS_S1_LOW, 8'hbc);
    @(posedge mclk);
    fe_one <= 13'h1234;
    wait_upd(n);
    wait_upd(n);
    rd_chk(`ALDZR_OFS_S1_HIGH, 8'h0a);
    rd_chk(`ALDZR_OFS_S1_LOW, 8'h34);
    rd_chk(`ALDZR_OFS_S1_HIGH, 8'h12);
  endtask
  // Entry below the threshold, holding inside the hysteresis band, exit above it.
  task automatic t_zone();
    int   cnts[4] = '{8000, 1000, 1500, 1510};
    int   n;
    logic dk;
    // Zone left behind by the result scenario; the first step leaves it for indoor.
    dk = exp_dark(1'b1, 13'h1234, 8'ha5, 8'h5a);
    wr(`ALDZR_OFS_DARK_THR, 8'h20);
    wr(`ALDZR_OFS_DARK_HYS, 8'h10);
    foreach (cnts[k]) begin
      @(posedge mclk);
      fe_one <= cnts[k][12:0];
      wait_upd(n);
      wait_upd(n);
      dk = exp_dark(dk, cnts[k], 32, 16);
      chk(dark_zone_active, dk);
      chk(backlight_level, dk ? `ALDZR_LEVEL_DARK : `ALDZR_LEVEL_INDOOR);
    end
    // Switching sensing off stops the refresh; the last result stays readable.
    @(posedge mclk);
    fe_en  <= 1'b0;
    fe_one <= 13'h0100;
    repeat (3 * REFRESH) @(posedge mclk);
    rd_chk(`ALDZR_OFS_S1_LOW, 8'he6);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_results();
    t_zone();
    end_sim();
  end
  // The tests need well under a thousand cycles; this limit only catches a hang.
  initial begin
    #(25 * 20000);
    n_errors++;
    end_sim();
  end
endmodule
